// ==== lss_pkg.sv ====
package lss_pkg;

  // ****************************************************************
  // frame layout, counted in link clock edges after the start edge
  // ****************************************************************
  localparam int unsigned LSS_CNT_W = 4;
  localparam logic [3:0] LSS_CNT_DIR  = 4'h1; // direction bit sampled
  localparam logic [3:0] LSS_CNT_ADDR = 4'h2; // address bit sampled
  localparam logic [3:0] LSS_CNT_LAST = 4'h9; // last data bit launched
  localparam logic [3:0] LSS_CNT_STAT = 4'ha; // status bit launched
  localparam logic [3:0] LSS_CNT_END  = 4'hb; // master samples status
  localparam logic [3:0] LSS_CNT_ONE  = 4'h1;

  // ****************************************************************
  // status bit values and status byte layout
  // ****************************************************************
  localparam logic LSS_STAT_OK   = 1'b0; // accepted or new data
  localparam logic LSS_STAT_FAIL = 1'b1; // rejected or old data
  localparam int unsigned LSS_RXF_BIT = 0;
  localparam int unsigned LSS_TXE_BIT = 1;
  localparam int unsigned LSS_RIE_BIT = 4;
  localparam int unsigned LSS_TIE_BIT = 5;
  localparam logic [7:0] LSS_BYTE_ZERO = 8'h00;

  // ****************************************************************
  // crossing widths
  // ****************************************************************
  localparam int unsigned LSS_L_SYNC_W = 6; // into the link domain
  localparam int unsigned LSS_S_SYNC_W = 2; // into the system domain

  // link frame states
  typedef enum logic [1:0] {
    LSS_IDLE = 2'b01,
    LSS_BUSY = 2'b10
  } lss_state_e;

  // decoded setup bits
  typedef enum logic [1:0] {
    LSS_OP_WRITE  = 2'h0,
    LSS_OP_UNDEF  = 2'h1,
    LSS_OP_READ   = 2'h2,
    LSS_OP_STATUS = 2'h3
  } lss_op_e;

  // direction then address select the operation
  function automatic lss_op_e lss_decode(input logic dir,
                                         input logic addr);
    lss_decode = lss_op_e'({dir, addr});
  endfunction : lss_decode

  // unused positions stay zero
  function automatic logic [7:0] lss_status_byte(input logic rxf,
                                                 input logic txe,
                                                 input logic rie,
                                                 input logic tie);
    logic [7:0] b;
    b = LSS_BYTE_ZERO;
    b[LSS_RXF_BIT] = rxf;
    b[LSS_TXE_BIT] = txe;
    b[LSS_RIE_BIT] = rie;
    b[LSS_TIE_BIT] = tie;
    lss_status_byte = b;
  endfunction : lss_status_byte

endpackage : lss_pkg

// ==== lss_legacy_slave.sv ====
`timescale 1ns/10ps
module lss_legacy_slave (
  input  logic                     clk_i,
  input  logic                     rst_i,
  input  logic                     sclk_i,
  input  logic                     sel_i,
  input  logic                     mosi_i,
  output logic                     miso_o,
  output logic [7:0]               rx_data_o,
  output logic                     rx_full_o,
  input  logic                     rx_take_i,
  input  logic [7:0]               tx_data_i,
  input  logic                     tx_load_i,
  output logic                     tx_empty_o,
  input  logic                     rx_full_irq_enable_i,
  input  logic                     tx_empty_irq_enable_i
);
  import lss_pkg::*;

  // ****************************************************************
  // system domain registers
  // ****************************************************************
  logic [7:0]              tx_data;
  logic                    wr_ack;
  logic                    rd_ack;
  logic [LSS_S_SYNC_W-1:0] s_sync1;
  logic [LSS_S_SYNC_W-1:0] s_sync2;
  logic [LSS_S_SYNC_W-1:0] s_sync3;
  logic                    wr_event;
  logic                    rd_event;

  // ****************************************************************
  // link domain registers
  // ****************************************************************
  logic                    lrst_s1;
  logic                    lrst_s2;
  logic [LSS_L_SYNC_W-1:0] l_sync1;
  logic [LSS_L_SYNC_W-1:0] l_sync2;
  lss_state_e              state;
  logic [LSS_CNT_W-1:0]    cnt;
  logic                    dir;
  lss_op_e                 op;
  logic [7:0]              shreg;
  logic [7:0]              old_byte;
  logic                    rd_new;
  logic                    wr_req;
  logic                    rd_req;
  logic [7:0]              wr_byte;

  // synchronised views, named by position in the sync vector, then the link nets derived from them
  logic                    rx_full_l;
  logic                    tx_empty_l;
  logic                    wr_ack_l;
  logic                    rd_ack_l;
  logic                    rie_l;
  logic                    tie_l;
  logic                    rx_busy;
  logic                    tx_avail;
  logic                    start;
  logic                    in_frame;
  lss_op_e                 cur_op;
  logic [7:0]              load_byte;
  logic [7:0]              stat_byte;

  // ****************************************************************
  // system domain: crossing from the link
  // ****************************************************************

  // toggle requests pass two flops, the third feeds the edge test and the acks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_sync1 <= '0;
      s_sync2 <= '0;
      s_sync3 <= '0;
    end else begin
      s_sync1 <= {rd_req, wr_req};
      s_sync2 <= s_sync1;
      s_sync3 <= s_sync2;
    end
  end

  assign wr_event = s_sync2[0] ^ s_sync3[0];
  assign rd_event = s_sync2[1] ^ s_sync3[1];

  // acks follow one cycle after the flag moved, so the link never
  // sees its pending mark drop before the flag change reaches it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ack <= 1'b0;
      rd_ack <= 1'b0;
    end else begin
      wr_ack <= s_sync3[0];
      rd_ack <= s_sync3[1];
    end
  end

  // ****************************************************************
  // system domain: receive holding register
  // ****************************************************************

  // the byte register is stable here: the link holds it until acked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_data_o <= LSS_BYTE_ZERO;
    end else if (wr_event) begin
      rx_data_o <= wr_byte;
    end
  end

  // a new byte arriving with a take in the same cycle keeps it full
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_full_o <= 1'b0;
    end else if (wr_event) begin
      rx_full_o <= 1'b1;
    end else if (rx_take_i) begin
      rx_full_o <= 1'b0;
    end
  end

  // ****************************************************************
  // system domain: transmit holding register
  // ****************************************************************

  // loads are ignored while a byte still waits for the master
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_data <= LSS_BYTE_ZERO;
    end else if (tx_load_i && tx_empty_o) begin
      tx_data <= tx_data_i;
    end
  end

  // a read that reported new data removes the byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_empty_o <= 1'b1;
    end else if (tx_load_i && tx_empty_o) begin
      tx_empty_o <= 1'b0;
    end else if (rd_event) begin
      tx_empty_o <= 1'b1;
    end
  end

  // ****************************************************************
  // link domain: reset and level crossing
  // ****************************************************************

  // the link clock may stop; reset only takes while it runs
  always_ff @(posedge sclk_i) begin
    lrst_s1 <= rst_i;
    lrst_s2 <= lrst_s1;
  end

  // flags and enables are levels: two flops each
  always_ff @(posedge sclk_i) begin
    if (lrst_s2) begin
      l_sync1 <= '0;
      l_sync2 <= '0;
    end else begin
      l_sync1 <= {tx_empty_irq_enable_i, rx_full_irq_enable_i,
                  rd_ack, wr_ack, tx_empty_o, rx_full_o};
      l_sync2 <= l_sync1;
    end
  end

  assign rx_full_l  = l_sync2[0];
  assign tx_empty_l = l_sync2[1];
  assign wr_ack_l   = l_sync2[2];
  assign rd_ack_l   = l_sync2[3];
  assign rie_l      = l_sync2[4];
  assign tie_l      = l_sync2[5];

  // an unacknowledged request counts as the flag already moved, so
  // a fast master cannot overrun the slow system side
  assign rx_busy  = rx_full_l | (wr_req ^ wr_ack_l);
  assign tx_avail = ~tx_empty_l & ~(rd_req ^ rd_ack_l);

  // ****************************************************************
  // link domain: frame sequencing
  // ****************************************************************

  // start needs data and select high on one edge
  assign start    = (state == LSS_IDLE) && sel_i && mosi_i;
  assign in_frame = (state == LSS_BUSY) && sel_i;
  assign cur_op   = lss_decode(dir, mosi_i);

  // status byte with unused positions forced low
  assign stat_byte = lss_status_byte(rx_busy, ~tx_avail, rie_l,
                                     tie_l);

  // byte loaded for the data phase of a read
  always_comb begin
    load_byte = LSS_BYTE_ZERO;
    case (cur_op)
      LSS_OP_STATUS: load_byte = stat_byte;
      LSS_OP_READ:   load_byte = tx_avail ? tx_data : old_byte;
      default:       load_byte = LSS_BYTE_ZERO;
    endcase
  end

  // frame state; dropping select mid frame abandons it
  always_ff @(posedge sclk_i) begin
    if (lrst_s2) begin
      state <= LSS_IDLE;
    end else begin
      case (state)
        LSS_IDLE: begin
          if (start) begin
            state <= LSS_BUSY;
          end
        end
        LSS_BUSY: begin
          if (!sel_i || cnt == LSS_CNT_END) begin
            state <= LSS_IDLE;
          end
        end
        default: state <= LSS_IDLE;
      endcase
    end
  end

  // edge count inside the frame
  always_ff @(posedge sclk_i) begin
    if (lrst_s2) begin
      cnt <= '0;
    end else if (start) begin
      cnt <= LSS_CNT_ONE;
    end else if (in_frame) begin
      cnt <= cnt + LSS_CNT_ONE;
    end else begin
      cnt <= '0;
    end
  end

  // setup bits
  always_ff @(posedge sclk_i) begin
    if (lrst_s2) begin
      dir <= 1'b0;
      op  <= LSS_OP_WRITE;
    end else if (in_frame && cnt == LSS_CNT_DIR) begin
      dir <= mosi_i;
    end else if (in_frame && cnt == LSS_CNT_ADDR) begin
      op <= cur_op;
    end
  end

  // ****************************************************************
  // link domain: shifting
  // ****************************************************************

  // one register serves both directions, top bit first
  always_ff @(posedge sclk_i) begin
    if (lrst_s2) begin
      shreg <= LSS_BYTE_ZERO;
    end else if (in_frame && cnt == LSS_CNT_ADDR) begin
      shreg <= {load_byte[6:0], 1'b0};
    end else if (in_frame && cnt > LSS_CNT_ADDR
                 && cnt < LSS_CNT_STAT) begin
      shreg <= {shreg[6:0], mosi_i};
    end
  end

  // the new/old verdict is fixed when the byte is loaded
  always_ff @(posedge sclk_i) begin
    if (lrst_s2) begin
      rd_new   <= 1'b0;
      old_byte <= LSS_BYTE_ZERO;
    end else if (in_frame && cnt == LSS_CNT_ADDR
                 && cur_op == LSS_OP_READ) begin
      rd_new <= tx_avail;
      if (tx_avail) begin
        old_byte <= tx_data; // replayed while the buffer is empty
      end
    end
  end

  // slave output: data bits, then the status bit, then low
  always_ff @(posedge sclk_i) begin
    if (lrst_s2) begin
      miso_o <= 1'b0;
    end else if (!in_frame) begin
      miso_o <= 1'b0;
    end else if (cnt == LSS_CNT_ADDR) begin
      miso_o <= load_byte[7];
    end else if (cnt > LSS_CNT_ADDR && cnt <= LSS_CNT_LAST) begin
      miso_o <= op[1] ? shreg[7] : 1'b0;
    end else if (cnt == LSS_CNT_STAT) begin
      case (op)
        LSS_OP_WRITE:
          miso_o <= rx_busy ? LSS_STAT_FAIL
                            : LSS_STAT_OK;
        LSS_OP_READ:
          miso_o <= rd_new ? LSS_STAT_OK
                           : LSS_STAT_FAIL;
        LSS_OP_STATUS:
          miso_o <= LSS_STAT_OK;
        default:
          miso_o <= LSS_STAT_OK;
      endcase
    end else begin
      miso_o <= 1'b0; // status held one clock only
    end
  end

  // ****************************************************************
  // link domain: commits toward the system side
  // ****************************************************************

  // a write commits as the last bit arrives; undefined op is inert
  always_ff @(posedge sclk_i) begin
    if (lrst_s2) begin
      wr_req  <= 1'b0;
      wr_byte <= LSS_BYTE_ZERO;
    end else if (in_frame && cnt == LSS_CNT_STAT
                 && op == LSS_OP_WRITE && !rx_busy) begin
      wr_byte <= {shreg[6:0], mosi_i};
      wr_req  <= ~wr_req;
    end
  end

  // a new-data read asks the system side to drop its byte
  always_ff @(posedge sclk_i) begin
    if (lrst_s2) begin
      rd_req <= 1'b0;
    end else if (in_frame && cnt == LSS_CNT_STAT
                 && op == LSS_OP_READ && rd_new) begin
      rd_req <= ~rd_req;
    end
  end

endmodule : lss_legacy_slave

// ==== lss_legacy_slave_properties.sv ====
`timescale 1ns/10ps
module lss_legacy_slave_properties (
  input logic       clk_i,
  input logic       rst_i,
  input logic       sclk_i,
  input logic       sel_i,
  input logic       mosi_i,
  input logic       miso_o,
  input logic [7:0] rx_data_o,
  input logic       rx_full_o,
  input logic       rx_take_i,
  input logic       tx_load_i,
  input logic       tx_empty_o
);
  import lss_pkg::*;
  logic       busy;
  logic [3:0] k;
  logic       dir;
  logic       adr;

  // ****************
  // frame tracking
  // ****************
  // k holds the index of the link edge now being sampled
  always_ff @(posedge sclk_i) begin
    if (rst_i || !sel_i) begin
      busy <= 1'b0;
      k    <= 4'h0;
    end else if (!busy) begin
      busy <= mosi_i;
      k    <= LSS_CNT_ONE;
    end else begin
      k <= k + LSS_CNT_ONE;
      if (k == LSS_CNT_END) busy <= 1'b0;
      if (k == LSS_CNT_DIR) dir <= mosi_i;
      if (k == LSS_CNT_ADDR) adr <= mosi_i;
    end
  end

  // ****************
  // link side
  // ****************
  idle_low_a: assert property (
    @(posedge sclk_i) disable iff (rst_i)
    (!busy || k <= LSS_CNT_ADDR) |-> !miso_o) else $error("miso not low");
  wr_quiet_a: assert property (
    @(posedge sclk_i) disable iff (rst_i)
    busy && !dir && k > LSS_CNT_ADDR && k < LSS_CNT_END |-> !miso_o)
    else $error("miso active in write data");
  pad_zero_a: assert property (
    @(posedge sclk_i) disable iff (rst_i)
    busy && dir && adr && (k == 4'h3 || k == 4'h4 || k == 4'h7 || k == 4'h8)
    |-> !miso_o) else $error("unused status bit set");
  stat_zero_a: assert property (
    @(posedge sclk_i) disable iff (rst_i)
    busy && k == LSS_CNT_END && dir && adr |-> !miso_o)
    else $error("status read trailer not zero");
  undef_ok_a: assert property (
    @(posedge sclk_i) disable iff (rst_i)
    busy && k == LSS_CNT_END && !dir && adr |-> !miso_o)
    else $error("undefined op status");
  wr_full_a: assert property (
    @(posedge sclk_i) disable iff (rst_i)
    busy && k == LSS_CNT_END && !dir && !adr && rx_full_o |-> miso_o)
    else $error("write to full buffer accepted");
  rd_old_a: assert property (
    @(posedge sclk_i) disable iff (rst_i)
    busy && k == LSS_CNT_END && dir && !adr && tx_empty_o |-> miso_o)
    else $error("empty read reported new");

  // ****************
  // system side
  // ****************
  take_clear_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rx_full_o && rx_take_i |=> !rx_full_o) else $error("take ignored");
  rx_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rx_full_o && !rx_take_i |=> rx_full_o && $stable(rx_data_o))
    else $error("held byte lost");
  load_fill_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tx_empty_o && tx_load_i |=> !tx_empty_o) else $error("load ignored");

  // main scenarios reached
  cover property (@(posedge sclk_i) busy && k == LSS_CNT_END && !dir && !adr);
  cover property (@(posedge sclk_i) busy && k == LSS_CNT_END && dir && !adr);
  // the tracker idles for the start edge, so the next frame shows one later
  cover property (@(posedge sclk_i) busy && k == LSS_CNT_END && dir ##2 busy);
endmodule : lss_legacy_slave_properties

bind lss_legacy_slave lss_legacy_slave_properties lss_props_inst (
  .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk_i), .sel_i(sel_i),
  .mosi_i(mosi_i), .miso_o(miso_o), .rx_data_o(rx_data_o),
  .rx_full_o(rx_full_o), .rx_take_i(rx_take_i), .tx_load_i(tx_load_i),
  .tx_empty_o(tx_empty_o));

// ==== lss_link_master.sv ====
`timescale 1ns/10ps
module lss_link_master (
  output logic sclk_o,
  output logic sel_o,
  output logic mosi_o,
  input  logic miso_i
);
  // clock stands low and select is dropped between frames unless keep holds it high
  initial begin
    sclk_o = 1'b0;
    sel_o  = 1'b0;
    mosi_o = 1'b0;
  end

  // free edges, select left as it is; the design needs them to sync flags
  task automatic idle(input int n);
    repeat (n) begin
      #3 sclk_o = 1'b1;
      #3 sclk_o = 1'b0;
    end
  endtask : idle

  // one twelve edge frame; keep leaves select high for the next one
  task automatic frame(input logic dir, input logic adr, input logic keep,
                       input logic [7:0] wd, output logic [7:0] rd,
                       output logic st);
    logic [10:0] bits;
    int          i;
    bits = {1'b1, dir, adr, wd};
    if (!sel_o) idle(4);
    sel_o  = 1'b1;
    mosi_o = 1'b1;
    for (i = 0; i < 12; i++) begin
      #3;
      if (i > 2 && i < 11) rd[10 - i] = miso_i;
      st = miso_i;
      sclk_o = 1'b1;
      #1 mosi_o = (i < 10) ? bits[9 - i] : ~mosi_o;
      #2 sclk_o = 1'b0;
    end
    if (!keep) begin
      sel_o  = 1'b0;
      mosi_o = 1'b0;
      idle(1);
    end
  endtask : frame

  // zero write whose select drops n edges after the start edge, before the commit
  task automatic cut(input int n);
    sel_o  = 1'b1;
    mosi_o = 1'b1;
    idle(1);
    mosi_o = 1'b0;
    idle(n);
    sel_o  = 1'b0;
    idle(1);
  endtask : cut
endmodule : lss_link_master

// ==== lss_legacy_slave_tb.sv ====
`timescale 1ns/10ps
module lss_legacy_slave_tb;
  import lss_pkg::*;
  logic        clk_i, rst_i, sclk, sel, mosi, miso, rx_full_o, rx_take_i;
  logic        tx_load_i, tx_empty_o, rie, tie, st;
  logic [7:0]  rx_data_o, tx_data_i, rd, d, t;
  logic [31:0] seed;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          n;

  lss_legacy_slave lss_legacy_slave_inst (
    .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .sel_i(sel),
    .mosi_i(mosi), .miso_o(miso), .rx_data_o(rx_data_o),
    .rx_full_o(rx_full_o), .rx_take_i(rx_take_i), .tx_data_i(tx_data_i),
    .tx_load_i(tx_load_i), .tx_empty_o(tx_empty_o),
    .rx_full_irq_enable_i(rie), .tx_empty_irq_enable_i(tie));
  lss_link_master lss_link_master_inst (
    .sclk_o(sclk), .sel_o(sel), .mosi_o(mosi), .miso_i(miso));

  // system clock, 40 ns
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
  endfunction : lfsr

  // expected status byte, unused positions zero
  function automatic logic [7:0] exp_stat(input logic rxf, input logic txe);
    exp_stat = {2'b00, tie, rie, 2'b00, txe, rxf};
  endfunction : exp_stat

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // bounded wait on rx_full_o (which=0) or tx_empty_o (which=1)
  task automatic wait_flag(input logic which, input logic v);
    int i;
    for (i = 0; i < 40 && (which ? tx_empty_o : rx_full_o) !== v; i++) begin
      @(posedge clk_i);
      #1;
    end
    if (i == 40) begin
      n_mismatch++;
      wrap_up();
    end
  endtask : wait_flag

  task automatic xfer(input logic dir, input logic adr, input logic keep,
                      input logic [7:0] wd);
    lss_link_master_inst.frame(dir, adr, keep, wd, rd, st);
  endtask : xfer

  // one cycle strobes, raised just after an edge
  task automatic take;
    @(posedge clk_i);
    #1 rx_take_i = 1'b1;
    @(posedge clk_i);
    #1 rx_take_i = 1'b0;
  endtask : take

  task automatic load(input logic [7:0] v);
    @(posedge clk_i);
    #1 tx_data_i = v;
    tx_load_i = 1'b1;
    @(posedge clk_i);
    #1 tx_load_i = 1'b0;
  endtask : load

  // ****************
  // main sequence
  // ****************
  initial begin
    seed = 32'h2171b97d;
    {rst_i, rx_take_i, tx_load_i} = 3'b100;
    {tx_data_i, rie, tie} = {8'h00, 2'b01};
    lss_link_master_inst.idle(6);
    repeat (4) @(posedge clk_i);
    #1 rst_i = 1'b0;
    check({6'h00, rx_full_o, tx_empty_o}, 8'h01);
    check(rx_data_o, 8'h00);
    // poll for transmit data first: empty buffer replays zero as old
    xfer(1'b1, 1'b0, 1'b0, 8'h00);
    check(rd, 8'h00);
    check({7'h00, st}, 8'h01);
    // status reads with select held high
    for (n = 0; n < 2; n++) begin
      xfer(1'b1, 1'b1, 1'b1, 8'h00);
      check(rd, exp_stat(1'b0, 1'b1));
      check({7'h00, st}, 8'h00);
    end
    // undefined write leaves the receive side alone
    xfer(1'b0, 1'b1, 1'b0, 8'hff);
    check({7'h00, st}, 8'h00);
    xfer(1'b1, 1'b1, 1'b0, 8'h00);
    check(rd, exp_stat(1'b0, 1'b1));
    // select dropped before the commit edge: the write never lands
    lss_link_master_inst.cut(9);
    repeat (8) @(posedge clk_i);
    #1;
    check({7'h00, rx_full_o}, 8'h00);
    for (n = 0; n < 6; n++) begin
      seed = lfsr(seed);
      d = (n == 0) ? 8'h80 : seed[7:0];
      t = (n == 1) ? 8'h01 : seed[23:16];
      @(posedge clk_i);
      #1 {rie, tie} = seed[9:8];
      xfer(1'b0, 1'b0, 1'b0, d);
      check({7'h00, st}, 8'h00);
      wait_flag(1'b0, 1'b1);
      check(rx_data_o, d);
      xfer(1'b0, 1'b0, 1'b0, ~d);
      check({7'h00, st}, 8'h01);
      xfer(1'b1, 1'b1, 1'b0, 8'h00);
      check(rd, exp_stat(1'b1, 1'b1));
      take();
      wait_flag(1'b0, 1'b0);
      // retry the rejected byte
      xfer(1'b0, 1'b0, 1'b0, ~d);
      check({7'h00, st}, 8'h00);
      wait_flag(1'b0, 1'b1);
      check(rx_data_o, ~d);
      take();
      wait_flag(1'b0, 1'b0);
      load(t);
      wait_flag(1'b1, 1'b0);
      xfer(1'b1, 1'b1, 1'b0, 8'h00);
      check(rd, exp_stat(1'b0, 1'b0));
      xfer(1'b1, 1'b0, 1'b0, 8'h00);
      check(rd, t);
      check({7'h00, st}, 8'h00);
      wait_flag(1'b1, 1'b1);
      xfer(1'b1, 1'b0, 1'b0, 8'h00);
      check(rd, t);
      check({7'h00, st}, 8'h01);
    end
    wrap_up();
  end
endmodule : lss_legacy_slave_tb
